// >>> hw/burst_sram_regs.svh
// timing counts and fixed values for the burst sram control block
`ifndef BURST_SRAM_REGS_SVH
`define BURST_SRAM_REGS_SVH
`define CLK_PERIOD_PS          5000
`define SLEEP_ENTRY_TIME_PS    10000
`define SLEEP_ENTRY_CYCLES     (`SLEEP_ENTRY_TIME_PS / `CLK_PERIOD_PS)
`define SLEEP_RECOVERY_TIME_PS 10000
`define SLEEP_RECOVERY_CYCLES  ((`SLEEP_RECOVERY_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BURST_OFS_BITS         2
`endif

// >>> hw/burst_sram_pkg.sv
// types for the burst sram control block
package burst_sram_pkg;
  typedef enum logic [2:0] {
    OP_DESEL  = 3'h0,
    OP_READ   = 3'h1,
    OP_WRITE  = 3'h3,
    OP_DUMMY  = 3'h2,
    OP_ABORT  = 3'h6,
    OP_SLEEP  = 3'h7
  } op_t;
endpackage : burst_sram_pkg

// >>> hw/pipelined_burst_sram_control.sv
// cycle-level control and storage of a pipelined burst sram
//
// Behaviour
// - all selects active, load low, write high: load address, start read burst.
// - load high in read burst: next burst address, selects and write ignored.
// - read with output enable inactive is a dummy read, bus stays released.
// - selects active, load low, write low, any lane low: start write burst.
// - load high in write burst: write next address with lanes sampled now.
// - write cycle with all lanes high aborts; nothing changes, bus released.
// - clock qualifier high: edge ignored, address and pipeline kept.
// - each lane select gates its own byte and parity bit.
// - any write cycle releases every data and parity pin.
// - output enable acts unsampled and is masked during write cycles.
// - read data driven only with output enable active and device selected.
// - pin state follows the pipelined operation and output enable.
// - after reset the device is deselected with the bus released.
// - sleep entry completes on the third clock rise after the request.
// - asleep, inputs ignored, bus released, contents kept.
// - deselect is pipelined; outputs release after the following clock rise.
// - burst steps two low bits, linear or interleaved, wrapping after four.
`timescale 1ns/10ps
`default_nettype none
`include "burst_sram_regs.svh"

module pipelined_burst_sram_control #(
  parameter int LANES     = 4,
  parameter int ADDR_W    = 19,
  parameter int DEPTH     = 1024
) (
  input  wire  logic                  clk,
  input  wire  logic                  rst_b,
  input  wire  logic                  clock_qualifier_n,
  input  wire  logic                  chip_select_all,
  input  wire  logic                  advance_or_load,
  input  wire  logic                  write_n,
  input  wire  logic [LANES-1:0]      byte_lane_select_n,
  input  wire  logic [ADDR_W-1:0]     address,
  input  wire  logic                  burst_order,
  input  wire  logic                  output_enable_n,
  input  wire  logic                  sleep_request,
  input  wire  logic [LANES*8-1:0]    data_in,
  input  wire  logic [LANES-1:0]      parity_in,
  output logic       [LANES*8-1:0]    data_out,
  output logic       [LANES-1:0]      parity_out,
  output logic                        data_oe_n,
  output logic                        asleep
);

  localparam int IDX_W = $clog2(DEPTH);
  localparam int LW    = 9;

  // sleep pin is asynchronous: two flops before use
  logic              sleep_s1_q;
  logic              sleep_s2_q;
  logic [1:0]        sleep_cnt_q;
  logic              asleep_q;
  logic [ADDR_W-1:0] base_q;
  logic [1:0]        ofs_cnt_q;
  logic              burst_write_q;
  logic              in_burst_q;
  burst_sram_pkg::op_t op_q;
  burst_sram_pkg::op_t op_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [LANES-1:0]  lanes_q;
  burst_sram_pkg::op_t out_op_q;
  logic [ADDR_W-1:0] out_addr_q;
  logic [LANES-1:0]  out_lanes_q;
  logic              fwd_hit;
  logic [LANES*8-1:0] rdata_q;
  logic [LANES-1:0]  rpar_q;
  logic [LANES*LW-1:0] mem [DEPTH];
  logic              edge_ok;
  logic [1:0]        step_ofs;

  function automatic logic [1:0] burst_ofs(input logic [1:0] first, input logic [1:0] n,
                                           input logic interleave);
    burst_ofs = interleave ? (first ^ n) : 2'(first + n);
  endfunction : burst_ofs

  function automatic logic [IDX_W-1:0] to_index(input logic [ADDR_W-1:0] a);
    to_index = IDX_W'(a);
  endfunction : to_index

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end
    else
    begin
      sleep_s1_q <= sleep_request;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  // two-flop sync already spends the two cycles allowed for entry
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      asleep_q    <= 1'b0;
      sleep_cnt_q <= 2'h0;
    end
    else
    begin
      asleep_q <= sleep_s2_q;
      if (sleep_s2_q)
        sleep_cnt_q <= 2'(`SLEEP_RECOVERY_CYCLES);
      else if (sleep_cnt_q != 2'h0)
        sleep_cnt_q <= sleep_cnt_q - 2'h1;
    end
  end

  assign asleep  = asleep_q;
  // clock qualifier and sleep both freeze the control path
  assign edge_ok = !clock_qualifier_n && !sleep_s2_q;
  assign step_ofs = burst_ofs(base_q[1:0], 2'(ofs_cnt_q + 2'h1), burst_order);

  always_comb
  begin
    op_d   = burst_sram_pkg::OP_DESEL;
    addr_d = addr_q;
    if (!advance_or_load)
    begin
      if (!chip_select_all)
        op_d = burst_sram_pkg::OP_DESEL;
      else if (write_n)
      begin
        op_d   = burst_sram_pkg::OP_READ;
        addr_d = address;
      end
      else
      begin
        op_d   = (&byte_lane_select_n) ? burst_sram_pkg::OP_ABORT
                                       : burst_sram_pkg::OP_WRITE;
        addr_d = address;
      end
    end
    else if (!in_burst_q)
      op_d = burst_sram_pkg::OP_DESEL;
    else
    begin
      addr_d = {base_q[ADDR_W-1:2], step_ofs};
      if (burst_write_q)
        op_d = (&byte_lane_select_n) ? burst_sram_pkg::OP_ABORT
                                     : burst_sram_pkg::OP_WRITE;
      else
        op_d = burst_sram_pkg::OP_READ;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_q          <= burst_sram_pkg::OP_DESEL;
      addr_q        <= '0;
      base_q        <= '0;
      ofs_cnt_q     <= 2'h0;
      burst_write_q <= 1'b0;
      in_burst_q    <= 1'b0;
      lanes_q       <= '1;
    end
    else if (sleep_s2_q)
    begin
      op_q       <= burst_sram_pkg::OP_SLEEP;
      in_burst_q <= 1'b0;
    end
    else if (edge_ok)
    begin
      op_q    <= op_d;
      addr_q  <= addr_d;
      lanes_q <= byte_lane_select_n;
      if (!advance_or_load)
      begin
        in_burst_q    <= chip_select_all;
        burst_write_q <= !write_n;
        base_q        <= address;
        ofs_cnt_q     <= 2'h0;
      end
      else if (in_burst_q)
        ofs_cnt_q <= 2'(ofs_cnt_q + 2'h1);
    end
  end

  // data stage: pins follow the operation one edge behind its address
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_op_q    <= burst_sram_pkg::OP_DESEL;
      out_addr_q  <= '0;
      out_lanes_q <= '1;
    end
    else if (sleep_s2_q)
      out_op_q <= burst_sram_pkg::OP_SLEEP;
    else if (edge_ok)
    begin
      out_op_q    <= op_q;
      out_addr_q  <= addr_q;
      out_lanes_q <= lanes_q;
    end
  end

  // write data is taken at the edge that closes the data stage, gated per lane
  always_ff @(posedge clk)
  begin
    if (edge_ok && out_op_q == burst_sram_pkg::OP_WRITE)
    begin
      for (int i = 0; i < LANES; i++)
        if (!out_lanes_q[i])
          mem[to_index(out_addr_q)][i*LW +: LW] <= {parity_in[i], data_in[i*8 +: 8]};
    end
  end

  // write to read of one word back to back: take the lanes off the bus
  assign fwd_hit = (out_op_q == burst_sram_pkg::OP_WRITE) && (out_addr_q == addr_q);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= '0;
      rpar_q  <= '0;
    end
    else if (edge_ok && op_q == burst_sram_pkg::OP_READ)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (fwd_hit && !out_lanes_q[i])
        begin
          rdata_q[i*8 +: 8] <= data_in[i*8 +: 8];
          rpar_q[i]         <= parity_in[i];
        end
        else
        begin
          rdata_q[i*8 +: 8] <= mem[to_index(addr_q)][i*LW +: 8];
          rpar_q[i]         <= mem[to_index(addr_q)][i*LW + 8];
        end
      end
    end
  end

  assign data_out   = rdata_q;
  assign parity_out = rpar_q;
  // enable is combinational on the unsampled output enable; write masks it
  assign data_oe_n  = !(out_op_q == burst_sram_pkg::OP_READ && !output_enable_n);

  read_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!data_oe_n) |-> (out_op_q == burst_sram_pkg::OP_READ && !output_enable_n))
    else $error("bus driven outside a read with output enable");

  write_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    (edge_ok && op_q == burst_sram_pkg::OP_WRITE) |=> data_oe_n)
    else $error("bus driven during write cycle");

  dummy_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (out_op_q == burst_sram_pkg::OP_READ && output_enable_n) |-> data_oe_n)
    else $error("dummy read drove bus");

  stall_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (clock_qualifier_n && !sleep_s2_q) |=>
      ($stable(addr_q) && $stable(op_q) && $stable(out_op_q)))
    else $error("stalled edge changed state");

  write_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    (out_op_q == burst_sram_pkg::OP_WRITE) |-> data_oe_n)
    else $error("output enable not masked in write");

  load_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
    (edge_ok && !advance_or_load && chip_select_all) |=> (addr_q == $past(address)))
    else $error("burst start did not load address");

  stage_pipe_a: assert property (@(posedge clk) disable iff (!rst_b)
    edge_ok |=> (out_op_q == $past(op_q)))
    else $error("data stage out of step");

  sleep_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    sleep_s2_q |=> ($stable(addr_q) && $stable(burst_write_q)))
    else $error("state moved while asleep");

  recover_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sleep_cnt_q != 2'h0) |-> data_oe_n)
    else $error("bus driven during sleep recovery");

  sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(sleep_s2_q) |-> ##1 (asleep && op_q == burst_sram_pkg::OP_SLEEP))
    else $error("sleep entry too slow");

  sleep_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    asleep |-> data_oe_n)
    else $error("bus driven while asleep");

  deselect_pipe_a: assert property (@(posedge clk) disable iff (!rst_b)
    (edge_ok && op_q == burst_sram_pkg::OP_DESEL) |=> data_oe_n)
    else $error("deselect did not release bus");

  burst_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    (edge_ok && advance_or_load && in_burst_q) |=>
      addr_q[1:0] == burst_ofs($past(base_q[1:0]), 2'($past(ofs_cnt_q) + 2'h1),
                               $past(burst_order)))
    else $error("burst address out of order");

  abort_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    (edge_ok && op_q == burst_sram_pkg::OP_ABORT) |=> data_oe_n)
    else $error("write abort drove bus");

  type_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (edge_ok && advance_or_load) |=> $stable(burst_write_q))
    else $error("burst type changed without load");

endmodule : pipelined_burst_sram_control
`default_nettype wire

// >>> bench/sram_ctrl_model.sv
// memory controller model on the bus side of the burst sram block
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_model (
  input  wire logic        clk,
  output logic             cqn,
  output logic             cs,
  output logic             adv,
  output logic             wn,
  output logic [3:0]       ln,
  output logic [18:0]      ad,
  output logic             slp,
  output logic [35:0]      wd
);
  initial
  begin
    {cqn, cs, adv, wn, ln, ad, slp, wd} = '0;
  end
  // idle data lines show the inverse of the last value, never a stale copy
  task automatic step(input logic c, a_l, w, s, input logic [3:0] l,
                      input logic [18:0] a, input logic dv, input logic [35:0] d);
    @(posedge clk);
    #1;
    cqn = s;
    cs = c;
    adv = a_l;
    wn = w;
    ln = l;
    ad = a;
    wd = dv ? d : ~wd;
  endtask : step
  task automatic doze(input logic on);
    @(posedge clk);
    #1;
    cs = 1'b0;
    adv = 1'b0;
    slp = on;
  endtask : doze
endmodule : sram_ctrl_model
`default_nettype wire

// >>> bench/pipelined_burst_sram_control_tb.sv
// self-checking bench for the pipelined burst sram control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module pipelined_burst_sram_control_tb;
  wire logic        cqn, cs, adv, wn, slp, doe, asl;
  wire logic [3:0]  ln, po;
  wire logic [18:0] ad;
  wire logic [35:0] wd;
  wire logic [31:0] dq;
  logic             clk, rst_b, bo, oen;
  int               checked, fail_count, cyc;
  logic [35:0]      mem [0:15];
  sram_ctrl_model m (.clk(clk), .cqn(cqn), .cs(cs), .adv(adv), .wn(wn), .ln(ln),
    .ad(ad), .slp(slp), .wd(wd));
  pipelined_burst_sram_control #(.LANES(4), .ADDR_W(19), .DEPTH(1024)) dut (
    .clk(clk), .rst_b(rst_b), .clock_qualifier_n(cqn), .chip_select_all(cs),
    .advance_or_load(adv), .write_n(wn), .byte_lane_select_n(ln), .address(ad),
    .burst_order(bo), .output_enable_n(oen), .sleep_request(slp), .data_in(wd[31:0]),
    .parity_in(wd[35:32]), .data_out(dq), .parity_out(po), .data_oe_n(doe),
    .asleep(asl));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // generous ceiling: the whole sequence needs well under 200 cycles
  always @(posedge clk)
    if (++cyc > 1000)
    begin
      fail_count++;
      test_done();
    end
  function automatic logic [18:0] ba(input logic [18:0] a, input logic [1:0] k, input logic o);
    return {a[18:2], o ? a[1:0] ^ k : a[1:0] + k};
  endfunction : ba
  task automatic wr(input logic [18:0] a, input logic o, input logic [3:0] l, input logic [35:0] s);
    logic [18:0] b;
    logic [35:0] w;
    bo = o;
    for (int k = 0; k < 6; k++)
    begin
      w = s + 36'(k) - 36'h2;
      m.step(k < 4, (k > 0) && (k < 4), 1'b0, 1'b0, l, a, k > 1, w);
      if (k > 1)
      begin
        `CHK(doe, 1'b1)
        b = ba(a, 2'(k - 2), o);
        for (int i = 0; i < 4; i++)
          if (!l[i])
          begin
            mem[b[3:0]][8*i+:8] = w[8*i+:8];
            mem[b[3:0]][32+i] = w[32+i];
          end
      end
    end
    $display("write burst at %h done", a);
  endtask : wr
  // write strobe held low on advance beats: the burst must stay a read
  task automatic rd(input logic [18:0] a, input logic o, input logic st);
    int j;
    bo = o;
    for (int k = 0; k < 7 + st; k++)
    begin
      m.step(k == 0, (k > 0) && (k < 4 + st), k == 0, st && (k == 2), 4'h0, a, 1'b0, '0);
      j = k - 2 - int'(st && (k > 2));
      if ((k >= 2) && (k <= 5 + st))
      begin
        `CHK(doe, oen)
        if (!oen)
          `CHK({po, dq}, mem[ba(a, 2'(j), o)][35:0])
      end
    end
    `CHK(doe, 1'b1)
    $display("read burst at %h done", a);
  endtask : rd
  task automatic test_done();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if ((fail_count == 0) && (checked > 0))
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  initial
  begin
    {rst_b, bo, oen} = '0;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    `CHK(doe, 1'b1)
    `CHK(asl, 1'b0)
    wr(19'h8, 1'b0, 4'h0, 36'h9_1234_5600);
    rd(19'h9, 1'b0, 1'b0);
    wr(19'h9, 1'b1, 4'hA, 36'h6_CAFE_0000);
    rd(19'hA, 1'b1, 1'b1);
    wr(19'h8, 1'b0, 4'hF, 36'h0);
    oen = 1'b1;
    rd(19'h8, 1'b0, 1'b0);
    oen = 1'b0;
    m.doze(1'b1);
    repeat (3) @(posedge clk);
    #1;
    `CHK(asl, 1'b1)
    m.step(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 19'h8, 1'b0, '0);
    m.step(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 19'h8, 1'b1, 36'h0);
    `CHK(doe, 1'b1)
    m.doze(1'b0);
    repeat (3) m.step(1'b0, 1'b0, 1'b1, 1'b0, 4'hF, 19'h0, 1'b0, '0);
    rd(19'h8, 1'b0, 1'b0);
    test_done();
  end
endmodule : pipelined_burst_sram_control_tb
`default_nettype wire
